// ==== rtl/quadrature_sample_decoder.sv ====
// quadrature phase sampler, transition decoder and accumulators
`timescale 1ns/1ps
`default_nettype none
module quadrature_sample_decoder
    import quad_pkg::*;
(
    input wire logic clk, // core clock, 20 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic start, // start task pulse
    input wire logic stop, // stop task pulse
    input wire logic clear_acc, // clears motion accumulator
    input wire logic clear_dbl, // clears double transition count
    input wire logic [period_sel_w-1:0] sample_period, // sample period select
    input wire logic phase_a, // encoder phase a
    input wire logic phase_b, // encoder phase b
    output logic running, // decoder is sampling
    output logic [sample_w-1:0] sample_value, // last signed sample
    output logic [acc_w-1:0] motion_accumulator, // signed motion total
    output logic [dbl_w-1:0] double_transition_count, // double transitions
    output logic sample_ready_event, // new sample written
    output logic accumulator_overflow_event, // step kept out of accumulator on overflow
    output logic stopped_event // decoder halted
);
    // ----------------------------------------
    // state and sampling strobe
    // ----------------------------------------
    run_state_e state; // run control state
    logic tick; // sample strobe from divider
    logic [1:0] prev_pair; // previous a,b sample
    logic [1:0] cur_pair; // current a,b pins
    logic [sample_w-1:0] next_sample; // decoded step of this sample
    logic decode_now; // a sample that gets decoded
    logic acc_ok; // step fits in the accumulator

    // the divider restarts from zero on every start, so the first strobe
    // lands one full period later and only primes the previous pair
    quad_tick_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(state != st_idle),
        .period_sel(sample_period),
        .sample_tick(tick)
    );

    assign cur_pair = {phase_a, phase_b};
    assign decode_now = tick && (state == st_run);
    assign running = (state != st_idle);

    // run control; stop wins over start when both arrive together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (start && !stop) begin
                        state <= st_prime;
                    end
                end
                st_prime: begin
                    if (stop) begin
                        state <= st_idle;
                    end else if (tick) begin
                        state <= st_run;
                    end
                end
                st_run: begin
                    if (stop) begin
                        state <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // stopped event: one pulse when a running decoder halts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stopped_event <= 1'b0;
        end else begin
            stopped_event <= stop && (state != st_idle);
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // gray order 00 -> 01 -> 11 -> 10 is the positive direction
    always_comb begin
        next_sample = sample_zero;
        case ({prev_pair, cur_pair})
            4'h1, 4'h7, 4'he, 4'h8: next_sample = sample_pos;
            4'h2, 4'hb, 4'hd, 4'h4: next_sample = sample_neg;
            4'h3, 4'h6, 4'h9, 4'hc: next_sample = sample_dbl;
            default: next_sample = sample_zero;
        endcase
    end

    // previous pair follows every strobe, including the priming one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_pair <= 2'h0;
        end else if (tick && state != st_idle) begin
            prev_pair <= cur_pair;
        end
    end

    // sample register and its ready pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_value <= sample_zero;
            sample_ready_event <= 1'b0;
        end else begin
            sample_ready_event <= decode_now;
            if (decode_now) begin
                sample_value <= next_sample;
            end
        end
    end

    // ----------------------------------------
    // accumulators
    // ----------------------------------------
    always_comb begin
        acc_ok = 1'b1;
        if (next_sample == sample_pos && motion_accumulator == acc_max) begin
            acc_ok = 1'b0;
        end
        if (next_sample == sample_neg && motion_accumulator == acc_min) begin
            acc_ok = 1'b0;
        end
    end

    // motion accumulator; a step in the clearing cycle is applied to zero, giving 1 or -1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motion_accumulator <= '0;
        end else if (clear_acc) begin
            if (decode_now && next_sample == sample_pos) begin
                motion_accumulator <= 16'h0001;
            end else if (decode_now && next_sample == sample_neg) begin
                motion_accumulator <= 16'hffff;
            end else begin
                motion_accumulator <= '0;
            end
        end else if (decode_now && acc_ok) begin
            if (next_sample == sample_pos) begin
                motion_accumulator <= motion_accumulator + 1'b1;
            end else if (next_sample == sample_neg) begin
                motion_accumulator <= motion_accumulator - 1'b1;
            end
        end
    end

    // double transition count saturates rather than wrapping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            double_transition_count <= '0;
        end else if (clear_dbl) begin
            double_transition_count <= (decode_now && next_sample == sample_dbl) ? 4'h1 : 4'h0;
        end else if (decode_now && next_sample == sample_dbl && double_transition_count != dbl_max) begin
            double_transition_count <= double_transition_count + 1'b1;
        end
    end

    // overflow event pulses the cycle after a discarded step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator_overflow_event <= 1'b0;
        end else begin
            accumulator_overflow_event <= decode_now && !acc_ok && !clear_acc;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_ready_follows: assert property (@(posedge clk) disable iff (!rst_n)
        decode_now |=> sample_ready_event) else $error("sample ready missing");
    a_prime_silent: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && state == st_prime) |=> !sample_ready_event) else $error("priming made a sample");
    a_fwd_step: assert property (@(posedge clk) disable iff (!rst_n)
        (decode_now && next_sample == sample_pos && acc_ok && !clear_acc)
        |=> motion_accumulator == $past(motion_accumulator) + 16'h0001) else $error("no increment");
    a_back_step: assert property (@(posedge clk) disable iff (!rst_n)
        (decode_now && next_sample == sample_neg && acc_ok && !clear_acc)
        |=> motion_accumulator == $past(motion_accumulator) - 16'h0001) else $error("no decrement");
    a_dbl_holds_acc: assert property (@(posedge clk) disable iff (!rst_n)
        (decode_now && next_sample == sample_dbl && !clear_acc)
        |=> $stable(motion_accumulator) && sample_value == sample_dbl) else $error("double moved acc");
    a_still_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (decode_now && prev_pair == cur_pair && !clear_acc && !clear_dbl)
        |=> sample_value == sample_zero && $stable(motion_accumulator) && $stable(double_transition_count))
        else $error("still pair changed state");
    a_ovf_discard: assert property (@(posedge clk) disable iff (!rst_n)
        accumulator_overflow_event |-> $stable(motion_accumulator)) else $error("overflow not discarded");
    a_stop_event: assert property (@(posedge clk) disable iff (!rst_n)
        (stop && running) |=> stopped_event && !running) else $error("stop not reported");
    a_tick_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !running |-> !tick) else $error("sampling while stopped");
    a_dbl_count: assert property (@(posedge clk) disable iff (!rst_n)
        (decode_now && next_sample == sample_dbl && !clear_dbl && double_transition_count != dbl_max)
        |=> double_transition_count == $past(double_transition_count) + 4'h1) else $error("double not counted");
    a_ovf_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (decode_now && !acc_ok && !clear_acc) |=> accumulator_overflow_event && $stable(motion_accumulator))
        else $error("overflow step not discarded");
    a_stop_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        stopped_event |=> !stopped_event) else $error("stopped event too long");
endmodule
`default_nettype wire

// ==== rtl/quad_pkg.sv ====
// constants shared by the quadrature sample decoder
package quad_pkg;
    localparam int unsigned clk_hz = 20_000_000; // core clock rate
    localparam int unsigned base_tick_ns = 1_000; // sample period unit, 1 us
    localparam int unsigned clk_period_ns = 1_000_000_000 / clk_hz;
    localparam int unsigned tick_cycles = base_tick_ns / clk_period_ns; // cycles per unit
    localparam int tick_w = 5; // width of the unit divider
    localparam logic [tick_w-1:0] tick_last = tick_w'(tick_cycles - 1);
    localparam int period_sel_w = 4; // sample period select width
    localparam int period_cnt_w = 17; // width of the period unit counter
    localparam int sample_w = 2; // signed sample value width
    localparam int acc_w = 16; // motion accumulator width
    localparam int dbl_w = 4; // double transition count width
    localparam logic [sample_w-1:0] sample_zero = 2'h0;
    localparam logic [sample_w-1:0] sample_pos = 2'h1;
    localparam logic [sample_w-1:0] sample_neg = 2'h3; // two's complement -1
    localparam logic [sample_w-1:0] sample_dbl = 2'h2; // flags a double transition
    localparam logic [acc_w-1:0] acc_max = 16'h7fff;
    localparam logic [acc_w-1:0] acc_min = 16'h8000;
    localparam logic [dbl_w-1:0] dbl_max = 4'hf;
    localparam logic [period_cnt_w-1:0] period_one = 17'h0_0001;
    typedef enum logic [1:0] {
        st_idle,
        st_prime,
        st_run
    } run_state_e;
endpackage

// ==== rtl/quad_tick_divider.sv ====
// divider producing the sample strobe from the core clock
`timescale 1ns/1ps
`default_nettype none
module quad_tick_divider
    import quad_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic run, // divider runs while high
    input wire logic [period_sel_w-1:0] period_sel, // period is 128 us shifted by this
    output logic sample_tick // one-cycle sample strobe
);
    // ----------------------------------------
    // unit tick and period counting
    // ----------------------------------------
    logic [tick_w-1:0] unit_cnt; // cycles inside one microsecond
    logic [period_cnt_w-1:0] period_cnt; // microseconds inside one period
    logic [period_cnt_w-1:0] period_len; // selected period in microseconds
    logic unit_tick; // one-cycle microsecond strobe

    // selection n gives 128 << n us up to n = 9; above that the shift overflows the counter width to zero
    assign period_len = period_cnt_w'(128) << period_sel;
    assign unit_tick = run && (unit_cnt == tick_last);

    // unit divider, held at zero while stopped so each start is aligned
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_cnt <= '0;
        end else if (!run || unit_tick) begin
            unit_cnt <= '0;
        end else begin
            unit_cnt <= unit_cnt + 1'b1;
        end
    end

    // period counter, fires the strobe on the last unit of a period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt <= '0;
        end else if (!run) begin
            period_cnt <= '0;
        end else if (unit_tick) begin
            if (period_cnt + period_one >= period_len) begin
                period_cnt <= '0;
            end else begin
                period_cnt <= period_cnt + period_one;
            end
        end
    end

    assign sample_tick = unit_tick && (period_cnt + period_one >= period_len);
endmodule
`default_nettype wire

// ==== bench/quad_encoder_model.sv ====
// behavioural incremental encoder driving the two phase lines
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic go, // apply one movement
    input wire logic [1:0] move, // 0 hold, 1 fwd, 2 back, 3 double
    output logic phase_a, // phase a line
    output logic phase_b // phase b line
);
    logic [1:0] pos; // place in the gray cycle
    // -------------------------------------------------------------------
    // position update
    // -------------------------------------------------------------------
    // starts at 11 so an unprimed compare against 00 would read as a double
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 2'h2;
        end else if (go) begin
            case (move)
                2'h1: pos <= pos + 2'h1; // forward quarter step
                2'h2: pos <= pos - 2'h1; // backward quarter step
                2'h3: pos <= pos + 2'h2; // too fast: both lines flip
                default: pos <= pos; // standing still
            endcase
        end
    end
    // gray order 00, 01, 11, 10 with a as the upper bit
    assign phase_a = pos[1];
    assign phase_b = pos[1] ^ pos[0];
endmodule
`default_nettype wire

// ==== bench/quadrature_sample_decoder_tb_top.sv ====
// self-checking bench for the quadrature sample decoder
`timescale 1ns/1ps
`default_nettype none
module quadrature_sample_decoder_tb_top
    import quad_pkg::*;
;
    logic clk = 0, rst_n = 0, start = 0, stop = 0, clear_acc = 0, clear_dbl = 0, go = 0; // drives
    logic [period_sel_w-1:0] sample_period = '0; // period select
    logic [1:0] mv = '0; // movement code
    logic phase_a, phase_b, running, sample_ready_event, accumulator_overflow_event, stopped_event;
    logic [sample_w-1:0] sample_value; // decoded sample
    logic [acc_w-1:0] motion_accumulator, exp_acc; // totals
    logic [dbl_w-1:0] double_transition_count, exp_dbl; // double counts
    logic [1:0] moves [15] = '{1, 1, 1, 1, 2, 2, 2, 2, 2, 0, 3, 3, 1, 3, 1}; // walk through all codes
    int fail_count = 0, n_tests = 0, cyc = 0, last = 0, t0 = 0; // bookkeeping
    always #25 clk = ~clk;
    quadrature_sample_decoder dut_u (.clk(clk), .rst_n(rst_n), .start(start), .stop(stop),
        .clear_acc(clear_acc), .clear_dbl(clear_dbl), .sample_period(sample_period),
        .phase_a(phase_a), .phase_b(phase_b), .running(running), .sample_value(sample_value),
        .motion_accumulator(motion_accumulator), .double_transition_count(double_transition_count),
        .sample_ready_event(sample_ready_event), .accumulator_overflow_event(accumulator_overflow_event),
        .stopped_event(stopped_event));
    quad_encoder_model enc_u (.clk(clk), .rst_n(rst_n), .go(go), .move(mv), .phase_a(phase_a),
        .phase_b(phase_b));
    // -------------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------------
    task automatic complete_run();
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // settle one ns past the edge so the edge's updates have landed
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // bounded wait; a hang is caught by the cycle ceiling below
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            tick();
            n++;
        end while (sample_ready_event !== 1'b1 && n < 12000);
    endtask
    task automatic do_move(logic [1:0] m);
        mv <= m;
        go <= 1'b1;
        tick();
        go <= 1'b0;
    endtask
    // expected sample code for a movement, straight from the decode table
    function automatic logic [sample_w-1:0] exp_val(logic [1:0] m);
        case (m)
            2'h1: return sample_pos;
            2'h2: return sample_neg;
            2'h3: return sample_dbl;
            default: return sample_zero;
        endcase
    endfunction
    // -------------------------------------------------------------------
    // cycle ceiling: whole run needs about 60k cycles
    // -------------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fail_count++;
            complete_run();
        end
    end
    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        exp_acc = '0;
        exp_dbl = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        start <= 1'b1;
        tick();
        start <= 1'b0;
        t0 = cyc;
        check("running", running, 1);
        wait_ready();
        check("first sample delay", (cyc - t0 > 5100 && cyc - t0 < 5140), 1);
        check("first sample", sample_value, sample_zero);
        last = cyc;
        foreach (moves[i]) begin
            do_move(moves[i]);
            wait_ready();
            if (moves[i] == 2'h1) exp_acc = exp_acc + 16'h0001;
            if (moves[i] == 2'h2) exp_acc = exp_acc - 16'h0001;
            if (moves[i] == 2'h3) exp_dbl = exp_dbl + 4'h1;
            check("sample interval", cyc - last, 2560);
            check("sample value", sample_value, exp_val(moves[i]));
            check("accumulator", motion_accumulator, exp_acc);
            check("double count", double_transition_count, exp_dbl);
            check("overflow event", accumulator_overflow_event, 0);
            last = cyc;
        end
        clear_acc <= 1'b1;
        tick();
        clear_acc <= 1'b0;
        check("cleared accumulator", motion_accumulator, 0);
        clear_dbl <= 1'b1;
        tick();
        clear_dbl <= 1'b0;
        check("cleared double count", double_transition_count, 0);
        stop <= 1'b1;
        tick();
        stop <= 1'b0;
        check("running after stop", running, 0);
        check("stopped event", stopped_event, 1);
        tick();
        check("stopped event length", stopped_event, 0);
        stop <= 1'b1;
        tick();
        stop <= 1'b0;
        check("idle stop event", stopped_event, 0);
        // period and any other setting change only while stopped
        sample_period <= 4'h1;
        check("idle before reconfig", running, 0);
        tick();
        start <= 1'b1;
        tick();
        start <= 1'b0;
        wait_ready();
        last = cyc;
        do_move(2'h2);
        wait_ready();
        check("long interval", cyc - last, 5120);
        check("restart sample", sample_value, sample_neg);
        check("restart accumulator", motion_accumulator, 16'hffff);
        complete_run();
    end
endmodule
`default_nettype wire
